// file: rtl/iqd_top.sv
// two-pass converter sequencer, quadrature mixer and bandwidth filter
// What this block does
// - one 13-bit sample word is produced per sample period, started by the 250 kHz sample clock.
// - the finished word is shifted serially into the mixer only after the whole conversion is done.
// - the first pass captures the 8-bit coarse word of the scaled, dithered input.
// - the 13-bit sample is the 8-bit residue word added to the 8-bit coarse word shifted up five bits, saturated.
// - each sample is multiplied by a 62.5 kHz sine and, separately, a 62.5 kHz cosine.
// - both references are the sample clock divided by four, so they stay locked to sampling.
// - the mixer gives a real stream and an imaginary stream side by side.
// - the bandwidth filter runs on the real and imaginary streams independently.
// - track-and-hold stays in hold for the whole time the converter digitizes a sample.
// - reset returns converter, filter and output logic to their initial state.
// - a falling sweep sync edge re-phases the references and the decimation state.
`include "iqd_cfg.svh"
module iqd_top #(
  parameter int DECIM = `IQD_DECIM,
  parameter int COARSE_POS = `IQD_COARSE_POS
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic SAMPLE_CLK,
  input wire logic SWEEP_SYNC_N,
  input wire logic [7:0] CONV_DATA,
  input wire logic CONV_DONE,
  output logic HOLD,
  output logic CONV_START,
  output logic CONV_PASS,
  output logic [7:0] RESID_WORD,
  output logic signed [`IQD_MIX_W+$clog2(DECIM)-1:0] I_OUT,
  output logic signed [`IQD_MIX_W+$clog2(DECIM)-1:0] Q_OUT,
  output logic OUT_VALID
);
  localparam int ACC_W = `IQD_MIX_W + $clog2(DECIM);
  localparam int BUDGET = `IQD_SAMPLE_CYC;
  localparam logic [8:0] BUDGET_LAST = 9'(BUDGET - 1);
  localparam logic [3:0] BIT_LAST = 4'(`IQD_WORD_W - 1);
  localparam logic [7:0] DEC_LAST = 8'(DECIM - 1);

  iqd_pkg::iqd_state_type st_q;
  iqd_pkg::iqd_state_type st_d;
  logic samp_prev_q;
  logic sync_prev_q;
  logic hold_q;
  logic start_q;
  logic pass_q;
  logic [7:0] coarse_q;
  logic [8:0] budget_q;
  iqd_pkg::iqd_word_type word_q;
  logic [3:0] bit_q;
  logic ser_bit_q;
  logic ser_en_q;
  logic ser_last_q;
  iqd_pkg::iqd_word_type rx_q;
  logic rx_valid_q;
  logic [7:0] dec_q;
  logic signed [ACC_W-1:0] acc_q [2];
  logic signed [ACC_W-1:0] out_q [2];
  logic out_valid_q;

  wire samp_rise_w = SAMPLE_CLK & ~samp_prev_q;
  wire sync_fall_w = sync_prev_q & ~SWEEP_SYNC_N;
  wire busy_w = (st_q == iqd_pkg::IQD_COARSE) ||
                (st_q == iqd_pkg::IQD_FINE);
  // a conversion that outlives its sample period is dropped, not stretched
  wire timeout_w = busy_w && (budget_q == BUDGET_LAST);
  wire done_w = CONV_DONE & ~start_q & ~timeout_w;
  // coarse word weighted up, residue overlaps its low bits for gain match
  wire [13:0] sum_w = (14'(coarse_q) << COARSE_POS) + 14'(CONV_DATA);
  wire [12:0] sum_sat_w = sum_w[13] ? `IQD_WORD_MAX : sum_w[12:0];
  wire dec_wrap_w = (dec_q == DEC_LAST);

  iqd_mix_if mif ();

  assign mif.sample = rx_q;
  assign mif.sample_valid = rx_valid_q;
  assign mif.phase_clear = sync_fall_w;

  iqd_mixer u_mixer (
    .clk(CLOCK),
    .rst(RESET),
    .mx(mif.mixer)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      iqd_pkg::IQD_TRACK: begin
        if (samp_rise_w) st_d = iqd_pkg::IQD_COARSE;
      end
      iqd_pkg::IQD_COARSE: begin
        if (timeout_w) st_d = iqd_pkg::IQD_TRACK;
        else if (done_w) st_d = iqd_pkg::IQD_FINE;
      end
      iqd_pkg::IQD_FINE: begin
        if (timeout_w) st_d = iqd_pkg::IQD_TRACK;
        else if (done_w) st_d = iqd_pkg::IQD_SHIFT;
      end
      iqd_pkg::IQD_SHIFT: begin
        if (bit_q == 4'h0) st_d = iqd_pkg::IQD_TRACK;
      end
      default: st_d = iqd_pkg::IQD_TRACK;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_q <= iqd_pkg::IQD_TRACK;
      samp_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
      budget_q <= '0;
    end else begin
      st_q <= st_d;
      samp_prev_q <= SAMPLE_CLK;
      sync_prev_q <= SWEEP_SYNC_N;
      budget_q <= busy_w ? budget_q + 9'h001 : 9'h000;
    end
  end

  // converter handshake: hold across both passes, one start per pass
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hold_q <= 1'b0;
      start_q <= 1'b0;
      pass_q <= 1'b0;
      coarse_q <= '0;
    end else begin
      start_q <= 1'b0;
      if (st_q == iqd_pkg::IQD_TRACK && samp_rise_w) begin
        hold_q <= 1'b1;
        start_q <= 1'b1;
        pass_q <= 1'b0;
      end else if (timeout_w) begin
        hold_q <= 1'b0;
      end else if (st_q == iqd_pkg::IQD_COARSE && done_w) begin
        coarse_q <= CONV_DATA;
        start_q <= 1'b1;
        pass_q <= 1'b1;
      end else if (st_q == iqd_pkg::IQD_FINE && done_w) begin
        hold_q <= 1'b0;
      end
    end
  end

  // word out MSB first, one bit per clock, then rebuilt at the mixer
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      word_q <= '0;
      bit_q <= '0;
      ser_bit_q <= 1'b0;
      ser_en_q <= 1'b0;
      ser_last_q <= 1'b0;
      rx_q <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      ser_en_q <= 1'b0;
      ser_last_q <= 1'b0;
      if (st_q == iqd_pkg::IQD_FINE && done_w) begin
        word_q <= sum_sat_w;
        bit_q <= BIT_LAST;
      end else if (st_q == iqd_pkg::IQD_SHIFT) begin
        ser_bit_q <= word_q[bit_q];
        ser_en_q <= 1'b1;
        ser_last_q <= (bit_q == 4'h0);
        bit_q <= bit_q - 4'h1;
      end
      if (ser_en_q) rx_q <= {rx_q[11:0], ser_bit_q};
      rx_valid_q <= ser_en_q & ser_last_q;
    end
  end

  // integrate-and-dump per stream; sweep sync restarts the dump count
  always_ff @(posedge CLOCK) begin
    if (RESET || sync_fall_w) begin
      dec_q <= '0;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= mif.mix_valid & dec_wrap_w;
      if (mif.mix_valid) dec_q <= dec_wrap_w ? 8'h00 : dec_q + 8'h01;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_stream
    wire signed [ACC_W-1:0] in_w = (ch == 0) ?
      ACC_W'(mif.mix_i) : ACC_W'(mif.mix_q);
    always_ff @(posedge CLOCK) begin
      if (RESET || sync_fall_w) begin
        acc_q[ch] <= '0;
        out_q[ch] <= '0;
      end else if (mif.mix_valid) begin
        acc_q[ch] <= dec_wrap_w ? '0 : acc_q[ch] + in_w;
        if (dec_wrap_w) out_q[ch] <= acc_q[ch] + in_w;
      end
    end
  end

  assign HOLD = hold_q;
  assign CONV_START = start_q;
  assign CONV_PASS = pass_q;
  assign RESID_WORD = coarse_q;
  assign I_OUT = out_q[0];
  assign Q_OUT = out_q[1];
  assign OUT_VALID = out_valid_q;

  // the dump count is 8 bits wide and the sum 14, hence these limits
  if (DECIM < 1 || DECIM > 256) begin : g_bad_decim
    $error("DECIM must lie in 1..256");
  end
  if (COARSE_POS < 0 || COARSE_POS > 5) begin : g_bad_pos
    $error("COARSE_POS out of range");
  end
  if (BUDGET > 511) begin : g_bad_budget
    $error("sample period does not fit the budget count");
  end

  hold_conv_a: assert property (@(posedge CLOCK) disable iff (RESET)
    busy_w |-> HOLD)
    else $error("track-and-hold released during conversion");
  start_pass_a: assert property (@(posedge CLOCK) disable iff (RESET)
    st_q == iqd_pkg::IQD_TRACK && samp_rise_w
    |=> CONV_START && !CONV_PASS && HOLD ##1 !CONV_START)
    else $error("sample edge did not start a first pass");
  coarse_take_a: assert property (@(posedge CLOCK) disable iff (RESET)
    st_q == iqd_pkg::IQD_COARSE && done_w
    |=> RESID_WORD == $past(CONV_DATA) && CONV_START && CONV_PASS)
    else $error("coarse word not captured on first-pass completion");
  word_sum_a: assert property (@(posedge CLOCK) disable iff (RESET)
    st_q == iqd_pkg::IQD_FINE && done_w
    |=> word_q == $past(sum_sat_w) && !HOLD)
    else $error("sample word is not coarse plus residue");
  shift_after_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $rose(ser_en_q) |-> !HOLD && $past(st_q) == iqd_pkg::IQD_SHIFT
    ##0 ser_en_q[*8])
    else $error("serial shift started before conversion completed");
  out_strobe_a: assert property (@(posedge CLOCK) disable iff (RESET)
    mif.mix_valid && dec_wrap_w && !sync_fall_w
    |=> OUT_VALID ##1 !OUT_VALID)
    else $error("filter output strobe missing or stretched");
  sync_clear_a: assert property (@(posedge CLOCK) disable iff (RESET)
    sync_fall_w |=> dec_q == 8'h00 && acc_q[0] == 0 && acc_q[1] == 0)
    else $error("sweep sync did not clear the decimation state");
  reset_idle_a: assert property (@(posedge CLOCK)
    RESET |=> st_q == iqd_pkg::IQD_TRACK && !HOLD && !OUT_VALID)
    else $error("reset did not return the block to idle");
endmodule

// file: rtl/iqd_cfg.svh
// constants for the quadrature downconverter front end
`ifndef IQD_CFG_SVH
`define IQD_CFG_SVH
`define IQD_CLOCK_KHZ 100000
`define IQD_SAMPLE_KHZ 250
`define IQD_SAMPLE_CYC (`IQD_CLOCK_KHZ / `IQD_SAMPLE_KHZ)
`define IQD_REF_DIV 4
`define IQD_WORD_W 13
`define IQD_PASS_W 8
`define IQD_MIX_W 14
`define IQD_COARSE_POS 5
`define IQD_DECIM 8
`define IQD_PHASE_RESET 2'h0
`define IQD_WORD_MAX 13'h1FFF
`endif

// file: rtl/iqd_pkg.sv
// types shared by the downconverter modules
package iqd_pkg;
  typedef enum logic [2:0] {
    IQD_TRACK,
    IQD_COARSE,
    IQD_FINE,
    IQD_SHIFT
  } iqd_state_type;
  typedef logic [12:0] iqd_word_type;
  typedef logic signed [13:0] iqd_mix_type;
endpackage

// file: rtl/iqd_mix_if.sv
// carrier between the converter sequencer and the quadrature mixer
interface iqd_mix_if;
  iqd_pkg::iqd_word_type sample;
  logic sample_valid;
  logic phase_clear;
  iqd_pkg::iqd_mix_type mix_i;
  iqd_pkg::iqd_mix_type mix_q;
  logic mix_valid;
  modport feed (
    output sample,
    output sample_valid,
    output phase_clear,
    input mix_i,
    input mix_q,
    input mix_valid
  );
  modport mixer (
    input sample,
    input sample_valid,
    input phase_clear,
    output mix_i,
    output mix_q,
    output mix_valid
  );
endinterface

// file: rtl/iqd_mixer.sv
// quarter-rate quadrature mixer
`include "iqd_cfg.svh"
module iqd_mixer (
  input wire logic clk,
  input wire logic rst,
  iqd_mix_if.mixer mx
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  iqd_pkg::iqd_mix_type s_w;
  iqd_pkg::iqd_mix_type neg_w;
  iqd_pkg::iqd_mix_type cos_w;
  iqd_pkg::iqd_mix_type sin_w;
  iqd_pkg::iqd_mix_type i_q;
  iqd_pkg::iqd_mix_type q_q;
  logic valid_q;

  // offset-binary word to signed, one guard bit so negation cannot wrap
  assign s_w = {~mx.sample[12], ~mx.sample[12], mx.sample[11:0]};
  assign neg_w = -s_w;
  // cosine +1,0,-1,0 and sine 0,+1,0,-1: no multiplier needed at fs/4
  assign cos_w = (phase_q == 2'h0) ? s_w :
                 (phase_q == 2'h2) ? neg_w : '0;
  assign sin_w = (phase_q == 2'h1) ? s_w :
                 (phase_q == 2'h3) ? neg_w : '0;
  // one step per sample: the references are the sample clock over four
  assign phase_d = mx.phase_clear ? `IQD_PHASE_RESET :
                   mx.sample_valid ? phase_q + 2'h1 : phase_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= `IQD_PHASE_RESET;
      i_q <= '0;
      q_q <= '0;
      valid_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      valid_q <= mx.sample_valid & ~mx.phase_clear;
      if (mx.sample_valid) begin
        i_q <= cos_w;
        q_q <= sin_w;
      end
    end
  end

  assign mx.mix_i = i_q;
  assign mx.mix_q = q_q;
  assign mx.mix_valid = valid_q;

  if (`IQD_REF_DIV != 4) begin : g_bad_div
    $error("mixer serves a divide by four only");
  end

  phase_step_a: assert property (@(posedge clk) disable iff (rst)
    mx.sample_valid && !mx.phase_clear |=> phase_q == $past(phase_q) + 2'h1)
    else $error("reference phase did not advance one step per sample");
  phase_clear_a: assert property (@(posedge clk) disable iff (rst)
    mx.phase_clear |=> phase_q == `IQD_PHASE_RESET && !valid_q)
    else $error("sweep sync did not re-phase the mixer");
  cos_seq_a: assert property (@(posedge clk) disable iff (rst)
    mx.sample_valid && !mx.phase_clear && phase_q == 2'h2
    |=> i_q == -$past(s_w) && q_q == 0)
    else $error("mixer output wrong at half cycle of the references");
  sin_seq_a: assert property (@(posedge clk) disable iff (rst)
    mx.sample_valid && !mx.phase_clear && phase_q == 2'h1
    |=> q_q == $past(s_w) && i_q == 0)
    else $error("mixer output wrong at quarter cycle of the references");
endmodule

// file: tb/iqd_conv_model.sv
// behavioural two-pass converter seen from the sequencer
module iqd_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic conv_pass,
  input wire logic [7:0] coarse,
  input wire logic [7:0] resid,
  input wire logic signed [15:0] dly,
  output logic [7:0] conv_data,
  output logic conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] cnt_q;
  logic pass_q;
  // a negative delay never answers, which forces the budget timeout
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= -16'sh1;
      pass_q <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 8'hA5;
    end else begin
      conv_done <= 1'b0;
      // off the done cycle the data lines wander so a stale read shows
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt_q <= dly;
        pass_q <= conv_pass;
      end else if (cnt_q == 16'sh0) begin
        conv_done <= 1'b1;
        conv_data <= pass_q ? resid : coarse;
        cnt_q <= -16'sh1;
      end else if (cnt_q > 16'sh0) begin
        cnt_q <= cnt_q - 16'sh1;
      end
    end
  end
endmodule

// file: tb/tb_iqd_top.sv
// self-checking bench for the quadrature downconverter front end
module tb_iqd_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEC = 4;
  localparam int OW = 14 + $clog2(DEC);
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic SAMPLE_CLK = 1'b0;
  logic SWEEP_SYNC_N = 1'b1;
  logic [7:0] CONV_DATA;
  logic CONV_DONE;
  logic HOLD, CONV_START, CONV_PASS, OUT_VALID;
  logic [7:0] RESID_WORD;
  logic signed [OW-1:0] I_OUT, Q_OUT, i_cap, q_cap;
  logic [7:0] coarse = 8'h00;
  logic [7:0] resid = 8'h00;
  logic signed [15:0] dly = 16'sh0;
  int mismatches = 0;
  int total_checks = 0;
  int starts = 0;
  int outs = 0;
  int hold_bad = 0;
  always #5 CLOCK = ~CLOCK;
  iqd_top #(.DECIM(DEC)) dut_u (.CLOCK(CLOCK), .RESET(RESET),
    .SAMPLE_CLK(SAMPLE_CLK), .SWEEP_SYNC_N(SWEEP_SYNC_N),
    .CONV_DATA(CONV_DATA), .CONV_DONE(CONV_DONE), .HOLD(HOLD),
    .CONV_START(CONV_START), .CONV_PASS(CONV_PASS),
    .RESID_WORD(RESID_WORD), .I_OUT(I_OUT), .Q_OUT(Q_OUT),
    .OUT_VALID(OUT_VALID));
  iqd_conv_model conv_u (.clk(CLOCK), .rst(RESET), .conv_start(CONV_START),
    .conv_pass(CONV_PASS), .coarse(coarse), .resid(resid), .dly(dly),
    .conv_data(CONV_DATA), .conv_done(CONV_DONE));
  always @(posedge CLOCK) begin
    if (CONV_START === 1'b1) starts++;
    if (CONV_DONE === 1'b1 && HOLD !== 1'b1) hold_bad++;
    if (OUT_VALID === 1'b1) begin
      outs++;
      i_cap = I_OUT;
      q_cap = Q_OUT;
    end
  end
  task automatic cmp(input string nm, input logic signed [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // offset binary sample after saturation, zero at 0x1000
  function automatic int word(input logic [7:0] a, b);
    int v;
    v = (int'(a) << 5) + int'(b);
    if (v > 8191) v = 8191;
    return v - 4096;
  endfunction
  task automatic do_reset();
    RESET <= 1'b1;
    repeat (20) @(posedge CLOCK);
    cmp("hold", 0, HOLD);
    cmp("resid_word", 0, RESID_WORD);
    cmp("i_out", 0, I_OUT);
    cmp("out_valid", 0, OUT_VALID);
    cmp("q_out", 0, Q_OUT);
    cmp("conv_start", 0, CONV_START);
    cmp("conv_pass", 0, CONV_PASS);
    RESET <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic samp(input logic [7:0] a, b);
    int n;
    n = starts;
    coarse <= a;
    resid <= b;
    SAMPLE_CLK <= 1'b1;
    repeat (200) @(posedge CLOCK);
    cmp("resid_word", a, RESID_WORD);
    cmp("start_pulses", n + 2, starts);
    cmp("conv_pass", 1, CONV_PASS);
    cmp("hold_idle", 0, HOLD);
    SAMPLE_CLK <= 1'b0;
    repeat (200) @(posedge CLOCK);
  endtask
  // four samples make one boxcar output; phases 0..3 of the references
  task automatic run4(input string nm, input logic [31:0] a, b);
    int n, s[4];
    n = outs;
    for (int k = 0; k < 4; k++) begin
      samp(a[8*k+:8], b[8*k+:8]);
      s[k] = word(a[8*k+:8], b[8*k+:8]);
      if (k < 3) cmp("early_output", n, outs);
    end
    cmp("out_count", n + 1, outs);
    cmp("i_out", s[0] - s[2], i_cap);
    cmp("q_out", s[1] - s[3], q_cap);
    $display("test %s done", nm);
  endtask
  task automatic t_sync();
    dly <= 16'sh5;
    samp(8'hC0, 8'h11);
    samp(8'h20, 8'h07);
    SWEEP_SYNC_N <= 1'b0;
    @(posedge CLOCK);
    SWEEP_SYNC_N <= 1'b1;
    @(posedge CLOCK);
    run4("sync_rephase", 32'h50A0_3388, 32'h0102_1E1F);
  endtask
  // fi 0 stalls the coarse pass, fi 1 the fine pass; both must be dropped
  task automatic t_timeout();
    int n;
    for (int fi = 0; fi < 2; fi++) begin
      coarse <= 8'h5A;
      dly <= (fi == 1) ? 16'sh0 : -16'sh1;
      SAMPLE_CLK <= 1'b1;
      repeat (3) @(posedge CLOCK);
      dly <= -16'sh1;
      repeat (447) @(posedge CLOCK);
      cmp("hold_after_timeout", 0, HOLD);
      cmp("pass_at_timeout", fi, CONV_PASS);
      SAMPLE_CLK <= 1'b0;
      dly <= 16'sh0;
      repeat (100) @(posedge CLOCK);
    end
    // a dropped sample that leaked in would shift phase and dump count
    run4("timeout_drop", 32'h1122_3344, 32'h0506_0708);
    n = outs;
    samp(8'h33, 8'h44);
    do_reset();
    cmp("out_count", n, outs);
    run4("timeout_then_reset", 32'h9080_7060, 32'h0310_2030);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    summarize();
  end
  initial begin
    do_reset();
    $display("test reset done");
    run4("basic_prompt", 32'h6070_8890, 32'hFF03_1F0F);
    run4("saturation", 32'h0080_00FF, 32'h0000_00FF);
    t_sync();
    t_timeout();
    cmp("done_outside_hold", 0, hold_bad);
    summarize();
  end
endmodule
